/* File: src/idpin_pkg.sv */
// Package: register map, field layout and bus types for the identity and pin bank
package idpin_pkg;
    localparam logic [11:0] IDPIN_ID_OFFS    = 12'h430;
    localparam logic [11:0] IDPIN_DATA_OFFS  = 12'h434;
    localparam logic [11:0] IDPIN_DIR_OFFS   = 12'h438;
    localparam logic [15:0] IDPIN_PART_ID    = 16'h5A5A; // Arbitrary value
    localparam logic [15:0] IDPIN_SILICON_REVISION     = 16'h0001; // Arbitrary value
    localparam int          IDPIN_PIN7_BIT   = 15;
    localparam int          IDPIN_PIN6_BIT   = 14;
    localparam logic [7:0]  IDPIN_OUT_RESET  = 8'h00;
    localparam logic [1:0]  IDPIN_DIR_RESET  = 2'h0;
    localparam logic [1:0]  IDPIN_HTRANS_NSQ = 2'h2;

    typedef struct packed {
        logic        wr_en;
        logic        rd_cap;
        logic [11:0] addr;
    } idpin_req_t;
endpackage

/* File: src/idpin_ahb_front.sv */
// AHB-Lite slave front end: address capture, write strobe, one wait state on reads
`timescale 1ns/10ps
`default_nettype none
module idpin_ahb_front
    import idpin_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // AHB-Lite address phase
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic        hready,
    // Handshake and request
    output logic             hreadyout,
    output idpin_req_t       req
);
    logic        dph_q;
    logic        wr_q;
    logic        wait_q;
    logic [11:0] addr_q;
    logic        take;

    assign take = hsel && htrans[1] && hready;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dph_q  <= 1'b0;
            wr_q   <= 1'b0;
            addr_q <= 12'h000;
        end else if (hreadyout) begin
            dph_q  <= take;
            wr_q   <= take && hwrite;
            addr_q <= haddr[11:0];
        end
    end

    // Reads wait one cycle so a write just before them is already visible
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= hreadyout && take && !hwrite;
        end
    end

    assign hreadyout  = !wait_q;
    // One driver for the whole carrier rather than one per member
    assign req = '{wr_en: dph_q && wr_q, rd_cap: wait_q, addr: addr_q};
endmodule
`default_nettype wire

/* File: src/idpin_regs.sv */
// Identity word and pin data word register bank behind an AHB-Lite slave
//
// How it works
// R01 - Identity word bits 31:16 hold a fixed read-only part identifier.
// R02 - Identity word bits 15:0 hold a fixed read-only silicon revision.
// R03 - Pin data word is read/write; low byte resets zero; bits 31:16 reserved.
// R04 - Bit 15 returns the live level of general pin 7 when input.
// R05 - Bit 14 returns the live level of general pin 6 when input.
// R06 - Writes to identity and read-only bits are ignored.
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module idpin_regs
    import idpin_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // General pin 7
    input  wire logic        general_pin_7_i,
    output logic             general_pin_7_o,
    output logic             general_pin_7_oe,
    // General pin 6
    input  wire logic        general_pin_6_i,
    output logic             general_pin_6_o,
    output logic             general_pin_6_oe
);
    idpin_req_t  req;
    logic [7:0]  out_q;
    logic [1:0]  dir_q;
    logic [31:0] rd_word;

    idpin_ahb_front u_front (
        .clock     (clock),
        .rst       (rst),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hready    (hready),
        .hreadyout (hreadyout),
        .req       (req)
    );

    // Only single whole-word transfers are supported, so hsize is not decoded
    assign hresp = 1'b0;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] offs);
        hit = (a[11:2] == offs[11:2]);
    endfunction

    // Writable low byte; upper bits and identity take no write
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            out_q <= IDPIN_OUT_RESET; // R03
        end else if (req.wr_en && hit(req.addr, IDPIN_DATA_OFFS)) begin
            out_q <= hwdata[7:0]; // R03 R06
        end
    end

    // Direction: bit 1 drives pin 7, bit 0 drives pin 6
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dir_q <= IDPIN_DIR_RESET;
        end else if (req.wr_en && hit(req.addr, IDPIN_DIR_OFFS)) begin
            dir_q <= hwdata[1:0];
        end
    end

    assign general_pin_7_o  = out_q[7];
    assign general_pin_6_o  = out_q[6];
    assign general_pin_7_oe = dir_q[1];
    assign general_pin_6_oe = dir_q[0];

    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit(req.addr, IDPIN_ID_OFFS)) begin
            rd_word = {IDPIN_PART_ID, IDPIN_SILICON_REVISION}; // R01 R02
        end else if (hit(req.addr, IDPIN_DATA_OFFS)) begin
            rd_word[7:0]           = out_q; // R03
            rd_word[IDPIN_PIN7_BIT] = general_pin_7_i && !dir_q[1]; // R04
            rd_word[IDPIN_PIN6_BIT] = general_pin_6_i && !dir_q[0]; // R05
        end else if (hit(req.addr, IDPIN_DIR_OFFS)) begin
            rd_word[1:0] = dir_q;
        end
    end

    // Read data held from the wait cycle until the next read
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (req.rd_cap) begin
            hrdata <= rd_word;
        end
    end

    sequence s_read_done;
        hreadyout && !req.rd_cap;
    endsequence

    property p_part_id;
        @(posedge clock) disable iff (rst)
        req.rd_cap && hit(req.addr, IDPIN_ID_OFFS)
            |=> s_read_done ##0 (hrdata[31:16] == IDPIN_PART_ID);
    endproperty
    a_part_id: assert property (p_part_id) else $error("part id wrong"); // R01

    property p_silicon_revision;
        @(posedge clock) disable iff (rst)
        req.rd_cap && hit(req.addr, IDPIN_ID_OFFS)
            |=> s_read_done ##0 (hrdata[15:0] == IDPIN_SILICON_REVISION);
    endproperty
    a_silicon_revision: assert property (p_silicon_revision) else $error("revision wrong"); // R02

    property p_data_write;
        @(posedge clock) disable iff (rst)
        req.wr_en && hit(req.addr, IDPIN_DATA_OFFS)
            |=> out_q == $past(hwdata[7:0]);
    endproperty
    a_data_write: assert property (p_data_write) else $error("low byte lost"); // R03

    property p_rsvd_zero;
        @(posedge clock) disable iff (rst)
        req.rd_cap && hit(req.addr, IDPIN_DATA_OFFS)
            |=> hrdata[31:16] == 16'h0000 && hrdata[7:0] == $past(out_q);
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("data word read bad"); // R03

    property p_pin7;
        @(posedge clock) disable iff (rst)
        req.rd_cap && hit(req.addr, IDPIN_DATA_OFFS) && !dir_q[1]
            |=> hrdata[IDPIN_PIN7_BIT] == $past(general_pin_7_i);
    endproperty
    a_pin7: assert property (p_pin7) else $error("pin 7 level wrong"); // R04

    property p_pin6;
        @(posedge clock) disable iff (rst)
        req.rd_cap && hit(req.addr, IDPIN_DATA_OFFS) && !dir_q[0]
            |=> hrdata[IDPIN_PIN6_BIT] == $past(general_pin_6_i);
    endproperty
    a_pin6: assert property (p_pin6) else $error("pin 6 level wrong"); // R05

    property p_ro_ignored;
        @(posedge clock) disable iff (rst)
        req.wr_en && hit(req.addr, IDPIN_ID_OFFS) |=> $stable(out_q) && $stable(dir_q);
    endproperty
    a_ro_ignored: assert property (p_ro_ignored) else $error("id write changed state"); // R06

    // Bus timing as seen by the master: reads wait one cycle, writes none
    sequence s_read_taken;
        hsel && htrans[1] && hready && hreadyout && !hwrite;
    endsequence

    sequence s_one_wait;
        !hreadyout ##1 hreadyout;
    endsequence

    property p_read_wait;
        @(posedge clock) disable iff (rst)
        s_read_taken |=> s_one_wait;
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");

    property p_write_no_wait;
        @(posedge clock) disable iff (rst)
        hsel && htrans[1] && hready && hreadyout && hwrite |=> hreadyout && req.wr_en;
    endproperty
    a_write_no_wait: assert property (p_write_no_wait) else $error("write stalled");

    property p_dir_write;
        @(posedge clock) disable iff (rst)
        req.wr_en && hit(req.addr, IDPIN_DIR_OFFS)
            |=> dir_q == $past(hwdata[1:0]);
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("direction write lost");

    // Pins follow the low byte as soon as the write lands
    property p_pin_drive;
        @(posedge clock) disable iff (rst)
        req.wr_en && hit(req.addr, IDPIN_DATA_OFFS)
            |=> general_pin_7_o == $past(hwdata[7]) && general_pin_6_o == $past(hwdata[6]);
    endproperty
    a_pin_drive: assert property (p_pin_drive) else $error("pin output wrong"); // R03

    property p_pin_enable;
        @(posedge clock) disable iff (rst)
        req.wr_en && hit(req.addr, IDPIN_DIR_OFFS)
            |=> general_pin_7_oe == $past(hwdata[1]) && general_pin_6_oe == $past(hwdata[0]);
    endproperty
    a_pin_enable: assert property (p_pin_enable) else $error("pin enable wrong");

    // A pin that the device drives reads back zero in its level bit
    property p_pin7_masked;
        @(posedge clock) disable iff (rst)
        req.rd_cap && hit(req.addr, IDPIN_DATA_OFFS) && dir_q[1]
            |=> !hrdata[IDPIN_PIN7_BIT];
    endproperty
    a_pin7_masked: assert property (p_pin7_masked) else $error("pin 7 not masked"); // R04

    property p_pin6_masked;
        @(posedge clock) disable iff (rst)
        req.rd_cap && hit(req.addr, IDPIN_DATA_OFFS) && dir_q[0]
            |=> !hrdata[IDPIN_PIN6_BIT];
    endproperty
    a_pin6_masked: assert property (p_pin6_masked) else $error("pin 6 not masked"); // R05

    property p_unmapped_zero;
        @(posedge clock) disable iff (rst)
        req.rd_cap && !hit(req.addr, IDPIN_ID_OFFS) && !hit(req.addr, IDPIN_DATA_OFFS)
            && !hit(req.addr, IDPIN_DIR_OFFS) |=> hrdata == 32'h0000_0000;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

    // Read data stands until the next capture, so a slow master still sees it
    property p_rdata_hold;
        @(posedge clock) disable iff (rst)
        !req.rd_cap |=> $stable(hrdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

    // No disable here: this one checks the reset itself
    property p_reset_state;
        @(posedge clock)
        rst |=> out_q == IDPIN_OUT_RESET && dir_q == IDPIN_DIR_RESET && hreadyout
            && hrdata == 32'h0000_0000;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset state wrong"); // R03
endmodule
`default_nettype wire

/* File: tb/test_identity_and_pin_state_regs.sv */
// Self-checking bench for the identity and pin data register bank
`timescale 1ns/10ps
`default_nettype none
module test_identity_and_pin_state_regs;
    import idpin_pkg::*;
    logic        clock, rst, hsel, hwrite, hreadyout, hresp;
    logic        p7_i, p6_i, p7_o, p7_oe, p6_o, p6_oe;
    logic [31:0] haddr, hwdata, hrdata, r, w;
    logic [1:0]  htrans, dir_m;
    logic [2:0]  hsize;
    logic [7:0]  out_m;
    int          err_count, n_compared;

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Bus ready fed back from the only slave
    idpin_regs dut_u (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .general_pin_7_i(p7_i), .general_pin_7_o(p7_o), .general_pin_7_oe(p7_oe),
        .general_pin_6_i(p6_i), .general_pin_6_o(p6_o), .general_pin_6_oe(p6_oe));

    task automatic end_of_test;
        $display("compared %0d, errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Ready comes from a flop and changes on the rising edge, so look at it mid-cycle where it has settled
    task automatic wait_rdy;
        int n;
        n = 0;
        @(negedge clock);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 20) begin
                err_count++;
                end_of_test;
            end
            @(negedge clock);
        end
    endtask

    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        haddr  <= {20'h00000, a};
        hwrite <= wr;
        htrans <= IDPIN_HTRANS_NSQ;
        wait_rdy;
        @(posedge clock);
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        r = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
        @(posedge clock);
    endtask

    // Pins configured as outputs read back zero in their level bits
    function automatic logic [31:0] exp_data();
        return {16'h0000, dir_m[1] ? 1'b0 : p7_i, dir_m[0] ? 1'b0 : p6_i, 6'h00, out_m};
    endfunction

    task automatic chk_regs;
        bus(1'b0, IDPIN_DATA_OFFS, 32'h0);
        chk("data", exp_data(), r);
        bus(1'b0, IDPIN_ID_OFFS, 32'h0);
        chk("ident", {IDPIN_PART_ID, IDPIN_SILICON_REVISION}, r);
        bus(1'b0, IDPIN_DIR_OFFS, 32'h0);
        chk("dir", {30'h0, dir_m}, r);
        chk("pins", {28'h0, out_m[7:6], dir_m}, {28'h0, p7_o, p6_o, p7_oe, p6_oe});
    endtask

    initial begin
        {hsel, hwrite, htrans, haddr, hwdata, p7_i, p6_i} = '0;
        hsize = 3'h2;
        rst = 1'b1;
        err_count = 0;
        n_compared = 0;
        out_m = 8'h00;
        dir_m = 2'h0;
        void'($urandom(32'hCC9EA8D3));
        repeat (5) @(posedge clock);
        rst  <= 1'b0;
        hsel <= 1'b1;
        chk_regs;
        for (int i = 0; i < 16; i++) begin
            w = $urandom;
            p7_i <= w[20];
            p6_i <= w[21];
            bus(1'b1, IDPIN_ID_OFFS, w);
            bus(1'b1, IDPIN_DIR_OFFS, {w[15:0], w[31:16]});
            dir_m = w[17:16];
            bus(1'b1, IDPIN_DATA_OFFS, w);
            out_m = w[7:0];
            // A deselected write must leave the model state untouched
            hsel <= 1'b0;
            bus(1'b1, IDPIN_DATA_OFFS, ~w);
            hsel <= 1'b1;
            chk_regs;
            bus(1'b1, 12'h43C, w);
            bus(1'b0, 12'h43C, 32'h0);
            chk("unmapped", 32'h0, r);
        end
        // Second reset in mid-run clears the low byte and direction
        rst <= 1'b1;
        @(posedge clock);
        rst <= 1'b0;
        out_m = 8'h00;
        dir_m = 2'h0;
        chk_regs;
        end_of_test;
    end
endmodule
`default_nettype wire
